// *** inc/pte_regs.svh ***
`ifndef PTE_REGS_SVH
`define PTE_REGS_SVH
// geometry
`define PTE_NUM_PERIPH   2
`define PTE_NUM_CHAN     4
`define PTE_AGE_MAX      8'hff
// address map: one peripheral space per peripheral, engine window inside it
`define PTE_SPACE_BIT    9
`define PTE_WIN_BASE     9'h100
`define PTE_OFF_RX_PTR   9'h100
`define PTE_OFF_RX_CNT   9'h104
`define PTE_OFF_TX_PTR   9'h108
`define PTE_OFF_TX_CNT   9'h10c
`define PTE_OFF_RX_NPTR  9'h110
`define PTE_OFF_RX_NCNT  9'h114
`define PTE_OFF_TX_NPTR  9'h118
`define PTE_OFF_TX_NCNT  9'h11c
`define PTE_OFF_CTRL     9'h120
`define PTE_OFF_STAT     9'h124
`define PTE_OFF_FLAGS    9'h128
// field positions within the window offset
`define PTE_OFF_DIR_BIT  3
`define PTE_OFF_NEXT_BIT 4
`define PTE_OFF_CNT_BIT  2
// control and status bits
`define PTE_RX_EN_BIT    0
`define PTE_RX_DIS_BIT   1
`define PTE_TX_EN_BIT    8
`define PTE_TX_DIS_BIT   9
`define PTE_FL_RX_END    0
`define PTE_FL_RX_FULL   1
`define PTE_FL_TX_END    4
`define PTE_FL_TX_EMPTY  5
// reset values and responses
`define PTE_RST_PTR      32'h0000_0000
`define PTE_RST_CNT      16'h0000
`define PTE_RESP_OKAY    2'h0
`define PTE_RESP_SLVERR  2'h2
`endif

// *** inc/pte_pkg.sv ***
package pte_pkg;
  `include "pte_regs.svh"

  typedef enum logic [3:0] {
    PTE_IDLE   = 4'h1,
    PTE_RX_WR  = 4'h2,
    PTE_TX_RD  = 4'h4,
    PTE_SETTLE = 4'h8
  } pte_fsm_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
  } pte_mem_req_t;

  typedef struct packed {
    logic        rx_ready;
    logic [1:0]  rx_size;
    logic [31:0] rx_data;
    logic        tx_ready;
    logic [1:0]  tx_size;
  } pte_per_in_t;

  typedef struct packed {
    logic        rx_take;
    logic        tx_load;
    logic [31:0] tx_data;
    logic        rx_end;
    logic        rx_full;
    logic        tx_end;
    logic        tx_empty;
  } pte_per_out_t;

  typedef struct packed {
    pte_fsm_t                              fsm;
    logic [1:0]                            cur_ch;
    logic [`PTE_NUM_CHAN-1:0][31:0]        ptr;
    logic [`PTE_NUM_CHAN-1:0][31:0]        nptr;
    logic [`PTE_NUM_CHAN-1:0][15:0]        cnt;
    logic [`PTE_NUM_CHAN-1:0][15:0]        ncnt;
    logic [`PTE_NUM_CHAN-1:0]              en;
    logic [`PTE_NUM_CHAN-1:0]              endf;
    logic [`PTE_NUM_CHAN-1:0][7:0]         age;
    pte_mem_req_t                          mem;
    logic [`PTE_NUM_PERIPH-1:0]            rx_take;
    logic [`PTE_NUM_PERIPH-1:0]            tx_load;
    logic [`PTE_NUM_PERIPH-1:0][31:0]      tx_data;
    logic                                  aw_full;
    logic [31:0]                           aw_addr;
    logic                                  w_full;
    logic [31:0]                           wdata;
    logic [3:0]                            wstrb;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  rvalid;
    logic [31:0]                           rdata;
    logic [1:0]                            rresp;
  } pte_state_t;
endpackage

// *** hw/pte_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - one receive, one transmit channel per peripheral
// - each channel: pointer, count, next pointer, next count
// - registers sit at offset 0x100 per peripheral
// - pointers and counts readable at any time
// - enable/disable bits; status shows enabled channels
// - receive end flag when receive count hits zero
// - receive full flag when both receive counts zero
// - transmit end flag when transmit count hits zero
// - transmit empty flag when both transmit counts zero
// - pointer advances by 1, 2, 4 or 8
// - written pointer used for the next transfer
// - count decrements per transfer; zero stops channel
// - zero count, zero next: block triggers, flag
// - written count restarts counting from new value
// - zero count with next: load next pointer, count
// - next count cleared when it is loaded
// - writing either count clears the end flag
// - receive: take holding data, then write memory
// - transmit: read memory, then load the peripheral
// - block done: flag peripheral; stop channel unless a next count is loaded
// - simultaneous same-direction requests: lower peripheral first
// - receive before transmit; then oldest request first
// - enable acts only without disable; zero ignored
module pte_top
  import pte_pkg::*;
(
  input  wire logic                               aclk,      // system clock
  input  wire logic                               aresetn,   // sync reset, low
  input  wire logic [31:0]                        s_awaddr,  // write address
  input  wire logic                               s_awvalid, // write address valid
  output logic                                    s_awready, // write address ready
  input  wire logic [31:0]                        s_wdata,   // write data
  input  wire logic [3:0]                         s_wstrb,   // byte strobes
  input  wire logic                               s_wvalid,  // write data valid
  output logic                                    s_wready,  // write data ready
  output logic [1:0]                              s_bresp,   // write response
  output logic                                    s_bvalid,  // write response valid
  input  wire logic                               s_bready,  // write response ready
  input  wire logic [31:0]                        s_araddr,  // read address
  input  wire logic                               s_arvalid, // read address valid
  output logic                                    s_arready, // read address ready
  output logic [31:0]                             s_rdata,   // read data
  output logic [1:0]                              s_rresp,   // read response
  output logic                                    s_rvalid,  // read data valid
  input  wire logic                               s_rready,  // read data ready
  output pte_mem_req_t                            mem_req,   // memory bus request
  input  wire logic                               mem_ack,   // grant and completion
  input  wire logic [31:0]                        mem_rdata, // memory read data
  input  wire pte_per_in_t  [`PTE_NUM_PERIPH-1:0] per_in,    // peripheral side in
  output pte_per_out_t      [`PTE_NUM_PERIPH-1:0] per_out    // peripheral side out
);

  pte_state_t s_reg;
  pte_state_t s_next;

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] pte_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus handshakes
  assign s_awready = !s_reg.aw_full && !s_reg.bvalid;
  assign s_wready  = !s_reg.w_full && !s_reg.bvalid;
  assign s_arready = !s_reg.rvalid;
  assign s_bvalid  = s_reg.bvalid;
  assign s_bresp   = s_reg.bresp;
  assign s_rvalid  = s_reg.rvalid;
  assign s_rdata   = s_reg.rdata;
  assign s_rresp   = s_reg.rresp;
  assign mem_req   = s_reg.mem;

  // peripheral outputs
  always_comb begin
    for (int p = 0; p < `PTE_NUM_PERIPH; p++) begin
      per_out[p].rx_take  = s_reg.rx_take[p];
      per_out[p].tx_load  = s_reg.tx_load[p];
      per_out[p].tx_data  = s_reg.tx_data[p];
      per_out[p].rx_end   = s_reg.endf[2*p];
      per_out[p].tx_end   = s_reg.endf[2*p+1];
      per_out[p].rx_full  = (s_reg.cnt[2*p] == 16'h0000) && (s_reg.ncnt[2*p] == 16'h0000);
      per_out[p].tx_empty = (s_reg.cnt[2*p+1] == 16'h0000)
                            && (s_reg.ncnt[2*p+1] == 16'h0000);
    end
  end

  // next-state logic
  always_comb begin
    logic [31:0]               wa;
    logic [8:0]                woff;
    logic                      wp;
    logic [31:0]               wv;
    logic [1:0]                wc;
    logic [31:0]               ra;
    logic [8:0]                roff;
    logic                      rp;
    logic [1:0]                rc;
    logic [`PTE_NUM_CHAN-1:0]  set_end;
    logic [`PTE_NUM_CHAN-1:0]  clr_end;
    logic [`PTE_NUM_CHAN-1:0]  pend;
    logic                      found;
    logic [1:0]                best;
    logic [15:0]               dec;
    logic [31:0]               flags;
    wa      = s_reg.aw_addr;
    woff    = wa[8:0];
    wp      = wa[`PTE_SPACE_BIT];
    wv      = 32'h0000_0000;
    wc      = 2'h0;
    ra      = s_araddr;
    roff    = ra[8:0];
    rp      = ra[`PTE_SPACE_BIT];
    rc      = 2'h0;
    set_end = '0;
    clr_end = '0;
    pend    = '0;
    found   = 1'b0;
    best    = 2'h0;
    dec     = 16'h0000;
    flags   = 32'h0000_0000;
    s_next  = s_reg;
    s_next.rx_take = '0;
    s_next.tx_load = '0;

    // completion of a memory access
    if (s_reg.mem.valid && mem_ack) begin
      s_next.mem.valid = 1'b0;
      s_next.fsm       = PTE_SETTLE;
      if (s_reg.fsm == PTE_TX_RD) begin
        s_next.tx_data[s_reg.cur_ch[1]] = mem_rdata;
        s_next.tx_load[s_reg.cur_ch[1]] = 1'b1;
      end
      s_next.ptr[s_reg.cur_ch] = s_reg.ptr[s_reg.cur_ch] + (32'h1 << s_reg.mem.size);
      dec = s_reg.cnt[s_reg.cur_ch] - 16'h0001;
      s_next.cnt[s_reg.cur_ch] = dec;
      if (dec == 16'h0000) begin
        set_end[s_reg.cur_ch] = 1'b1;
        if (s_reg.ncnt[s_reg.cur_ch] != 16'h0000) begin
          s_next.cnt[s_reg.cur_ch]  = s_reg.ncnt[s_reg.cur_ch];
          s_next.ptr[s_reg.cur_ch]  = s_reg.nptr[s_reg.cur_ch];
          s_next.ncnt[s_reg.cur_ch] = 16'h0000;
        end
      end
    end else if (s_reg.fsm == PTE_SETTLE) begin
      s_next.fsm = PTE_IDLE;
    end

    // bus write capture
    if (s_awvalid && s_awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      s_next.w_full = 1'b1;
      s_next.wdata  = s_wdata;
      s_next.wstrb  = s_wstrb;
    end
    if (s_reg.bvalid && s_bready) begin
      s_next.bvalid = 1'b0;
    end

    // bus write execution, software value overrides the engine's update
    if (s_reg.aw_full && s_reg.w_full) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = `PTE_RESP_OKAY;
      wc = {wp, woff[`PTE_OFF_DIR_BIT]};
      if (wa[31:10] != 22'h0 || woff < `PTE_WIN_BASE || woff > `PTE_OFF_FLAGS
          || wa[1:0] != 2'h0) begin
        s_next.bresp = `PTE_RESP_SLVERR;
      end else if (woff == `PTE_OFF_CTRL) begin
        wv = pte_merge(32'h0000_0000, s_reg.wdata, s_reg.wstrb);
        if (wv[`PTE_RX_DIS_BIT]) begin
          s_next.en[2*wp] = 1'b0;
        end else if (wv[`PTE_RX_EN_BIT]) begin
          s_next.en[2*wp] = 1'b1;
        end
        if (wv[`PTE_TX_DIS_BIT]) begin
          s_next.en[2*wp+1] = 1'b0;
        end else if (wv[`PTE_TX_EN_BIT]) begin
          s_next.en[2*wp+1] = 1'b1;
        end
      end else if (woff < `PTE_OFF_CTRL) begin
        if (!woff[`PTE_OFF_CNT_BIT] && !woff[`PTE_OFF_NEXT_BIT]) begin
          s_next.ptr[wc] = pte_merge(s_reg.ptr[wc], s_reg.wdata, s_reg.wstrb);
        end else if (!woff[`PTE_OFF_CNT_BIT]) begin
          s_next.nptr[wc] = pte_merge(s_reg.nptr[wc], s_reg.wdata, s_reg.wstrb);
        end else if (!woff[`PTE_OFF_NEXT_BIT]) begin
          wv = pte_merge({16'h0000, s_reg.cnt[wc]}, s_reg.wdata, s_reg.wstrb);
          s_next.cnt[wc] = wv[15:0];
          clr_end[wc]    = 1'b1;
        end else begin
          wv = pte_merge({16'h0000, s_reg.ncnt[wc]}, s_reg.wdata, s_reg.wstrb);
          s_next.ncnt[wc] = wv[15:0];
          clr_end[wc]     = 1'b1;
        end
      end
    end

    // end flags: a set in the same cycle as a clear wins
    s_next.endf = (s_reg.endf & ~clr_end) | set_end;

    // bus read
    if (s_reg.rvalid && s_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `PTE_RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      rc = {rp, roff[`PTE_OFF_DIR_BIT]};
      flags[`PTE_FL_RX_END]   = s_reg.endf[2*rp];
      flags[`PTE_FL_RX_FULL]  = per_out[rp].rx_full;
      flags[`PTE_FL_TX_END]   = s_reg.endf[2*rp+1];
      flags[`PTE_FL_TX_EMPTY] = per_out[rp].tx_empty;
      if (ra[31:10] != 22'h0 || roff < `PTE_WIN_BASE || roff > `PTE_OFF_FLAGS
          || ra[1:0] != 2'h0) begin
        s_next.rresp = `PTE_RESP_SLVERR;
      end else if (roff == `PTE_OFF_FLAGS) begin
        s_next.rdata = flags;
      end else if (roff == `PTE_OFF_STAT) begin
        s_next.rdata[`PTE_RX_EN_BIT] = s_reg.en[2*rp];
        s_next.rdata[`PTE_TX_EN_BIT] = s_reg.en[2*rp+1];
      end else if (roff == `PTE_OFF_CTRL) begin
        s_next.rdata = 32'h0000_0000;
      end else if (!roff[`PTE_OFF_CNT_BIT] && !roff[`PTE_OFF_NEXT_BIT]) begin
        s_next.rdata = s_reg.ptr[rc];
      end else if (!roff[`PTE_OFF_CNT_BIT]) begin
        s_next.rdata = s_reg.nptr[rc];
      end else if (!roff[`PTE_OFF_NEXT_BIT]) begin
        s_next.rdata = {16'h0000, s_reg.cnt[rc]};
      end else begin
        s_next.rdata = {16'h0000, s_reg.ncnt[rc]};
      end
    end

    // pending triggers and their waiting age
    for (int c = 0; c < `PTE_NUM_CHAN; c++) begin
      pend[c] = (c[0] ? per_in[c/2].tx_ready : per_in[c/2].rx_ready)
                && s_reg.en[c] && (s_reg.cnt[c] != 16'h0000);
      if (!pend[c]) begin
        s_next.age[c] = 8'h00;
      end else if (s_reg.age[c] != `PTE_AGE_MAX) begin
        s_next.age[c] = s_reg.age[c] + 8'h01;
      end
    end

    // arbitration: receive first, then oldest, then lowest peripheral
    for (int c = 0; c < `PTE_NUM_CHAN; c++) begin
      if (pend[c]) begin
        if (!found) begin
          found = 1'b1;
          best  = c[1:0];
        end else if (!c[0] && best[0]) begin
          best = c[1:0];
        end else if (c[0] == best[0] && s_reg.age[c] > s_reg.age[best]) begin
          best = c[1:0];
        end
      end
    end

    // start a transfer
    if (s_reg.fsm == PTE_IDLE && found) begin
      s_next.cur_ch     = best;
      s_next.age[best]  = 8'h00;
      s_next.mem.valid  = 1'b1;
      s_next.mem.addr   = s_reg.ptr[best];
      if (!best[0]) begin
        s_next.fsm          = PTE_RX_WR;
        s_next.mem.write    = 1'b1;
        s_next.mem.wdata    = per_in[best[1]].rx_data;
        s_next.mem.size     = per_in[best[1]].rx_size;
        s_next.rx_take[best[1]] = 1'b1;
      end else begin
        s_next.fsm          = PTE_TX_RD;
        s_next.mem.write    = 1'b0;
        s_next.mem.wdata    = 32'h0000_0000;
        s_next.mem.size     = per_in[best[1]].tx_size;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg         <= '0;
      s_reg.fsm     <= PTE_IDLE;
      s_reg.ptr     <= {`PTE_NUM_CHAN{`PTE_RST_PTR}};
      s_reg.cnt     <= {`PTE_NUM_CHAN{`PTE_RST_CNT}};
      s_reg.bresp   <= `PTE_RESP_OKAY;
      s_reg.rresp   <= `PTE_RESP_OKAY;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// *** bench/pte_props.sv ***
`timescale 1ns/1ps
`include "pte_regs.svh"
module pte_props
  import pte_pkg::*;
(
  input wire logic                 aclk,      // clock
  input wire logic                 aresetn,   // reset, low
  input wire logic                 s_arvalid, // read address valid
  input wire logic                 s_arready, // read address ready
  input wire logic                 s_rvalid,  // read data valid
  input wire logic                 s_bvalid,  // write response valid
  input wire pte_mem_req_t         mem_req,   // memory request
  input wire logic                 mem_ack,   // memory completion
  input wire pte_per_out_t [`PTE_NUM_PERIPH-1:0] per_out // peripheral side
);
  logic ack_w;
  logic ack_r;

  // completed memory writes and reads
  assign ack_w = mem_req.valid && mem_ack && mem_req.write;
  assign ack_r = mem_req.valid && mem_ack && !mem_req.write;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_take_start: assert property ($rose(mem_req.valid) |->
    mem_req.write == (per_out[0].rx_take || per_out[1].rx_take)) else $error("take mismatch");
  a_take_pulse: assert property (per_out[0].rx_take |=> !per_out[0].rx_take)
    else $error("take too long");
  a_load_after: assert property (ack_r |=> per_out[0].tx_load || per_out[1].tx_load)
    else $error("no load after read");
  a_req_stable: assert property (mem_req.valid && !mem_ack |=>
    mem_req.valid && $stable(mem_req.write)) else $error("request dropped");
  a_settle_gap: assert property (mem_req.valid && mem_ack |=> !mem_req.valid [*2])
    else $error("no settle gap");
  a_rx_end_cause: assert property ($rose(per_out[0].rx_end) |-> $past(ack_w))
    else $error("rx end without transfer");
  a_tx_end_cause: assert property ($rose(per_out[1].tx_end) |-> $past(ack_r))
    else $error("tx end without transfer");
  a_end_clear: assert property ($fell(per_out[0].rx_end) && $past(aresetn) |->
    $rose(s_bvalid)) else $error("end flag cleared without write");
  a_read_next: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read late");
endmodule

bind pte_top pte_props i_pte_props (.aclk, .aresetn, .s_arvalid, .s_arready, .s_rvalid,
  .s_bvalid, .mem_req, .mem_ack, .per_out);

// *** bench/pte_mem_model.sv ***
`timescale 1ns/1ps
module pte_mem_model
  import pte_pkg::*;
(
  input  wire logic         aclk,     // clock
  input  wire logic         aresetn,  // reset, low
  input  wire pte_mem_req_t mem_req,  // engine request
  output logic              mem_ack,  // grant and completion
  output logic [31:0]       mem_rdata // read data
);
  logic [1:0] wait_cnt;
  logic       slow;

  // every other request answered late; idle data bus keeps toggling
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      slow      <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) begin
        if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
          mem_ack  <= 1'b1;
          wait_cnt <= 2'h0;
          slow     <= !slow;
          if (!mem_req.write) mem_rdata <= ~mem_req.addr; // data is address inverted
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import pte_pkg::*;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [31:0]        awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0]         wstrb = 4'hf;
  logic               awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic               bready = 1'b1, rready = 1'b1;
  logic               awready, wready, bvalid, arready, rvalid, mem_ack;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata, mem_rdata, last_wd;
  pte_mem_req_t       mem_req;
  pte_per_in_t  [1:0] per_in = '0;
  pte_per_out_t [1:0] per_out;
  logic [31:0]        log_q[$];
  int                 errors = 0;
  int                 n_compared = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  pte_top i_pte_top (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .per_in(per_in), .per_out(per_out));
  pte_mem_model i_pte_mem_model (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // log memory accesses; a served peripheral drops its request
  always @(posedge aclk) begin
    if (mem_req.valid && mem_ack) begin
      log_q.push_back(mem_req.addr);
      last_wd <= mem_req.wdata;
    end
    for (int p = 0; p < 2; p++) begin
      if (per_out[p].rx_take) per_in[p].rx_ready <= 1'b0;
      if (per_out[p].tx_load) per_in[p].tx_ready <= 1'b0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    if (n >= 100) errors++; // a write that never answers is a mismatch
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    if (n >= 100) errors++; // a read that never answers is a mismatch
    chk(nm, e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic wr(input int p, input logic [8:0] o, input logic [31:0] d);
    axi_wr(32'(p) * 32'h200 + {23'h0, o}, d, 4'hf);
  endtask

  task automatic rd(input string nm, input int p, input logic [8:0] o, input logic [31:0] e);
    rd_chk(nm, 32'(p) * 32'h200 + {23'h0, o}, e, 2'h0);
  endtask

  // raise peripheral requests with transfer size and receive data
  task automatic go(input int p, input logic rxf, input logic txf, input logic [1:0] sz,
                    input logic [31:0] d);
    if (rxf) per_in[p].rx_ready <= 1'b1;
    if (txf) per_in[p].tx_ready <= 1'b1;
    per_in[p].rx_size <= sz;
    per_in[p].tx_size <= sz;
    per_in[p].rx_data <= d;
  endtask

  task automatic wait_log(input int n);
    int k;
    k = 0;
    while (log_q.size() < n && k < 300) begin
      @(posedge aclk);
      k++;
    end
    chk("mem_count", 32'(n), 32'(log_q.size()));
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_regs();
    rd("rx_ptr", 0, 9'h100, 32'h0);
    rd("flags", 1, 9'h128, 32'h22);
    wr(1, 9'h114, 32'h1234_5678);
    axi_wr(32'h314, 32'h0000_00ab, 4'h1);
    rd("rx_ncnt", 1, 9'h114, 32'h56ab);
    wr(1, 9'h114, 32'h0);
    rd_chk("unmapped", 32'h400, 32'h0, 2'h2);
  endtask

  task automatic t_rx();
    wr(0, 9'h100, 32'h1000);
    wr(0, 9'h104, 32'h2);
    wr(0, 9'h110, 32'h2000);
    wr(0, 9'h114, 32'h1);
    wr(0, 9'h120, 32'h1);
    go(0, 1'b1, 1'b0, 2'h2, 32'hcafe_0001);
    wait_log(1);
    chk("rx_addr", 32'h1000, log_q[0]);
    chk("rx_wdata", 32'hcafe_0001, last_wd);
    rd("rx_ptr", 0, 9'h100, 32'h1004);
    rd("rx_cnt", 0, 9'h104, 32'h1);
    wr(0, 9'h100, 32'h1800);
    go(0, 1'b1, 1'b0, 2'h0, 32'h55);
    wait_log(2);
    chk("rx_addr", 32'h1800, log_q[1]);
    rd("rx_ptr", 0, 9'h100, 32'h2000);
    rd("rx_ncnt", 0, 9'h114, 32'h0);
    rd("flags", 0, 9'h128, 32'h21);
    chk("rx_end_pin", 32'h1, {31'h0, per_out[0].rx_end});
    go(0, 1'b1, 1'b0, 2'h1, 32'h1234);
    wait_log(3);
    rd("rx_ptr", 0, 9'h100, 32'h2002);
    rd("flags", 0, 9'h128, 32'h23);
    chk("rx_full_pin", 32'h1, {31'h0, per_out[0].rx_full});
    go(0, 1'b1, 1'b0, 2'h2, 32'h0);
    repeat (20) @(posedge aclk);
    chk("blocked", 32'h3, 32'(log_q.size()));
    per_in[0].rx_ready <= 1'b0;
    wr(0, 9'h104, 32'h0);
    rd("flags", 0, 9'h128, 32'h22);
  endtask

  task automatic t_tx();
    wr(1, 9'h108, 32'h3000);
    wr(1, 9'h10c, 32'h1);
    wr(1, 9'h120, 32'h300);
    rd("status", 1, 9'h124, 32'h0);
    wr(1, 9'h120, 32'h100);
    rd("status", 1, 9'h124, 32'h100);
    go(1, 1'b0, 1'b1, 2'h2, 32'h0);
    wait_log(4);
    chk("tx_addr", 32'h3000, log_q[3]);
    chk("tx_data", 32'hffff_cfff, per_out[1].tx_data);
    rd("tx_ptr", 1, 9'h108, 32'h3004);
    rd("flags", 1, 9'h128, 32'h32);
    chk("tx_end_pin", 32'h1, {31'h0, per_out[1].tx_end});
    chk("tx_empty_pin", 32'h1, {31'h0, per_out[1].tx_empty});
  endtask

  task automatic t_prio();
    wr(0, 9'h100, 32'h4000);
    wr(0, 9'h104, 32'h1);
    wr(1, 9'h100, 32'h5000);
    wr(1, 9'h104, 32'h1);
    wr(1, 9'h120, 32'h1);
    wr(0, 9'h108, 32'h6000);
    wr(0, 9'h10c, 32'h1);
    wr(0, 9'h120, 32'h100);
    go(0, 1'b1, 1'b1, 2'h2, 32'h4);
    go(1, 1'b1, 1'b0, 2'h2, 32'h5);
    wait_log(7);
    chk("first", 32'h4000, log_q[4]);
    chk("second", 32'h5000, log_q[5]);
    chk("third", 32'h6000, log_q[6]);
    wr(0, 9'h120, 32'h2);
    rd("status", 0, 9'h124, 32'h100);
  endtask

  task automatic test_done();
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    t_prio();
    test_done();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    test_done();
  end
endmodule
